// *** core/system_flags_bank.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "sysflags_defines.svh"
module system_flags_bank (
	input  wire logic                CORE_CLK,
	input  wire logic                RST,
	input  wire logic                RETIRE,
	input  wire logic                INTERRUPT_RETURN_DONE,
	input  wire sysflags_pkg::reg64_t INTERRUPT_RETURN_FLAGS,
	input  wire logic                TASK_SWITCH,
	input  wire logic                TASK_GATE_XFER,
	input  wire sysflags_pkg::reg64_t TASK_FLAGS,
	input  wire logic                POPF,
	input  wire sysflags_pkg::reg64_t POPF_DATA,
	input  wire logic                IF_WRITE,
	input  wire logic                IF_VALUE,
	input  wire logic                EXC_TAKEN,
	input  wire logic                STR_INTERRUPTED,
	input  wire logic                DB_IBP,
	input  wire logic                MEM_ACCESS,
	input  wire logic                UNALIGNED,
	input  wire logic                SVM_INSN,
	input  wire logic                ALIGN_MASK_CTRL,
	input  wire logic                V86_MODE_EXT,
	input  wire logic                PROT_VIRT_INTS,
	input  wire sysflags_pkg::priv_t CUR_PRIV_LEVEL,
	input  wire logic                PAGING_EN,
	input  wire logic                CS_LONG,
	input  wire logic                MSR_RD,
	input  wire logic                MSR_WR,
	input  wire logic [31:0]         MSR_ADDR,
	input  wire sysflags_pkg::reg64_t MSR_WDATA,
	output sysflags_pkg::reg64_t     MSR_RDATA,
	output logic                     MSR_ACK,
	output logic                     MSR_GP,
	output sysflags_pkg::reg64_t     FLAGS_Q,
	output sysflags_pkg::reg64_t     EXTENDED_FEATURE_ENABLES_Q,
	output sysflags_pkg::reg64_t     STACK_FLAGS,
	output logic                     STACK_VALID,
	output logic                     ALIGN_FAULT,
	output logic                     VIF_GP,
	output logic                     UD_FAULT,
	output logic                     SYSCALL_EN,
	output logic                     NX_EN,
	output logic                     LIMIT_CHECK_EN,
	output logic                     FAST_FP_SAVE,
	output logic                     TCE_NARROW,
	output logic                     VIF_REDIRECT,
	output sysflags_pkg::op_mode_t   OP_MODE
);
	import sysflags_pkg::*;

	feature_ctx_if ctx ();

	reg64_t flags_r;
	reg64_t flags_nxt;
	reg64_t extended_feature_enables_r;
	logic   rf_hold_r;
	logic   rf_hold_nxt;
	logic   paging_q_r;
	logic   extended_feature_enables_hit;
	logic   priv_ok;
	logic   lma_match;
	logic   extended_feature_enables_wr_ok;
	logic   vif_fault;
	logic   lma_nxt;

	feature_decode u_decode (
		.ctx (ctx.decode)
	);

	assign ctx.extended_feature_enables    = extended_feature_enables_r;
	assign ctx.current_privilege_level     = CUR_PRIV_LEVEL;
	assign ctx.io_privilege_level    = flags_r[`FLG_IO_PRIVILEGE_LEVEL_HI:`FLG_IO_PRIVILEGE_LEVEL_LO];
	assign ctx.cs_long = CS_LONG;
	assign ctx.vme     = V86_MODE_EXT;
	assign ctx.pvi     = PROT_VIRT_INTS;

	// Enabling virtual interrupts from v86 code while one is pending
	assign vif_fault = IF_WRITE & IF_VALUE & ctx.vif_redirect
		& flags_r[`FLG_VM] & flags_r[`FLG_VIP];

	// Flags register next value
	always_comb begin
		flags_nxt = flags_r;
		if (INTERRUPT_RETURN_DONE) begin
			// Full image reload, mode bit included
			flags_nxt = (INTERRUPT_RETURN_FLAGS & `FLAGS_KEEP_MASK) | `FLAGS_RESET;
		end else if (TASK_SWITCH) begin
			flags_nxt = (TASK_FLAGS & `FLAGS_KEEP_MASK) | `FLAGS_RESET;
		end else if (POPF) begin
			// Mode bit and resume flag are left untouched
			flags_nxt = (POPF_DATA & `FLAGS_POP_MASK)
				| (flags_r & ~`FLAGS_POP_MASK);
		end else if (IF_WRITE && !vif_fault) begin
			if (ctx.vif_redirect) begin
				flags_nxt[`FLG_VIF] = IF_VALUE;
			end else begin
				flags_nxt[`FLG_IF] = IF_VALUE;
			end
		end
		// Ordinary completion drops the resume flag unless held
		if (RETIRE && !rf_hold_r && !INTERRUPT_RETURN_DONE && !TASK_SWITCH) begin
			flags_nxt[`FLG_RF] = 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			flags_r <= `FLAGS_RESET;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// Hold keeps the flag across exactly one following completion
	always_comb begin
		rf_hold_nxt = rf_hold_r;
		if (INTERRUPT_RETURN_DONE && INTERRUPT_RETURN_FLAGS[`FLG_RF]) begin
			rf_hold_nxt = 1'b1;
		end else if (TASK_GATE_XFER) begin
			rf_hold_nxt = 1'b1;
		end else if (RETIRE) begin
			rf_hold_nxt = 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			rf_hold_r <= 1'b0;
		end else begin
			rf_hold_r <= rf_hold_nxt;
		end
	end

	// Image pushed on the interrupt stack
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			STACK_FLAGS <= `FLAGS_RESET;
			STACK_VALID <= 1'b0;
		end else begin
			STACK_VALID <= EXC_TAKEN | STR_INTERRUPTED;
			if (EXC_TAKEN && DB_IBP) begin
				STACK_FLAGS <= flags_r & ~(64'h1 << `FLG_RF);
			end else if (EXC_TAKEN || STR_INTERRUPTED) begin
				STACK_FLAGS <= flags_r | (64'h1 << `FLG_RF);
			end
		end
	end

	// Extended feature register access
	assign extended_feature_enables_hit   = (MSR_RD | MSR_WR) & (MSR_ADDR == `EXTENDED_FEATURE_ENABLES_ADDR);
	assign priv_ok    = (CUR_PRIV_LEVEL == `CPL_KERNEL);
	assign lma_match  = (MSR_WDATA[`EFR_LMA] == extended_feature_enables_r[`EFR_LMA]);
	assign extended_feature_enables_wr_ok = extended_feature_enables_hit & MSR_WR & priv_ok & lma_match;

	// Long mode becomes active only on a later paging enable
	always_comb begin
		if (!PAGING_EN) begin
			lma_nxt = 1'b0;
		end else if (!paging_q_r && extended_feature_enables_r[`EFR_LME]) begin
			lma_nxt = 1'b1;
		end else begin
			lma_nxt = extended_feature_enables_r[`EFR_LMA];
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			paging_q_r <= 1'b0;
		end else begin
			paging_q_r <= PAGING_EN;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			extended_feature_enables_r <= `EXTENDED_FEATURE_ENABLES_RESET;
		end else begin
			if (extended_feature_enables_wr_ok) begin
				extended_feature_enables_r <= (MSR_WDATA & `EXTENDED_FEATURE_ENABLES_WR_MASK) | (extended_feature_enables_r & ~`EXTENDED_FEATURE_ENABLES_WR_MASK);
			end
			extended_feature_enables_r[`EFR_LMA] <= lma_nxt;
		end
	end

	// Answer one cycle after the request; other addresses belong elsewhere
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			MSR_ACK   <= 1'b0;
			MSR_GP    <= 1'b0;
			MSR_RDATA <= 64'h0;
		end else begin
			MSR_ACK <= extended_feature_enables_hit;
			MSR_GP  <= extended_feature_enables_hit & (!priv_ok | (MSR_WR & !lma_match));
			if (extended_feature_enables_hit && MSR_RD && priv_ok) begin
				MSR_RDATA <= extended_feature_enables_r;
			end else begin
				MSR_RDATA <= 64'h0;
			end
		end
	end

	// Faults raised toward the pipeline
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ALIGN_FAULT <= 1'b0;
			VIF_GP      <= 1'b0;
			UD_FAULT    <= 1'b0;
		end else begin
			ALIGN_FAULT <= MEM_ACCESS & UNALIGNED & flags_r[`FLG_AC]
				& ALIGN_MASK_CTRL & (CUR_PRIV_LEVEL == `CPL_USER);
			VIF_GP      <= vif_fault;
			UD_FAULT    <= SVM_INSN & !extended_feature_enables_r[`EFR_SECURE_VM_ENABLE];
		end
	end

	// Registered copies of state and decoded enables
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			FLAGS_Q        <= `FLAGS_RESET;
			EXTENDED_FEATURE_ENABLES_Q         <= `EXTENDED_FEATURE_ENABLES_RESET;
			SYSCALL_EN     <= 1'b0;
			NX_EN          <= 1'b0;
			LIMIT_CHECK_EN <= 1'b0;
			FAST_FP_SAVE   <= 1'b0;
			TCE_NARROW     <= 1'b0;
			VIF_REDIRECT   <= 1'b0;
			OP_MODE        <= MODE_LEGACY;
		end else begin
			FLAGS_Q        <= flags_r;
			EXTENDED_FEATURE_ENABLES_Q         <= extended_feature_enables_r;
			SYSCALL_EN     <= ctx.syscall_ok;
			NX_EN          <= ctx.nx_on;
			LIMIT_CHECK_EN <= ctx.limit_on;
			FAST_FP_SAVE   <= ctx.fast_save;
			TCE_NARROW     <= ctx.tce_narrow;
			VIF_REDIRECT   <= ctx.vif_redirect;
			OP_MODE        <= ctx.mode;
		end
	end

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);

	a_rf_hold_arm: assert property (
		(INTERRUPT_RETURN_DONE && INTERRUPT_RETURN_FLAGS[`FLG_RF]) |=> rf_hold_r && flags_r[`FLG_RF]
	) else $error("resume hold not armed by return");

	a_rf_held_once: assert property (
		(RETIRE && rf_hold_r && flags_r[`FLG_RF] && !INTERRUPT_RETURN_DONE && !TASK_SWITCH)
		|=> flags_r[`FLG_RF]
	) else $error("resume flag lost after return");

	a_rf_cleared: assert property (
		(RETIRE && !rf_hold_r && !INTERRUPT_RETURN_DONE && !TASK_SWITCH) |=> !flags_r[`FLG_RF]
	) else $error("resume flag not cleared on completion");

	a_stack_rf_set: assert property (
		((STR_INTERRUPTED || EXC_TAKEN) && !(EXC_TAKEN && DB_IBP))
		|=> STACK_VALID && STACK_FLAGS[`FLG_RF]
	) else $error("stacked resume flag not set");

	a_stack_rf_ibp: assert property (
		(EXC_TAKEN && DB_IBP) |=> STACK_VALID && !STACK_FLAGS[`FLG_RF]
	) else $error("stacked resume flag set on breakpoint");

	a_vm_popf_stable: assert property (
		(POPF && !INTERRUPT_RETURN_DONE && !TASK_SWITCH) |=> $stable(flags_r[`FLG_VM])
	) else $error("pop-flags changed mode bit");

	a_popf_id: assert property (
		(POPF && !INTERRUPT_RETURN_DONE && !TASK_SWITCH) |=> flags_r[`FLG_ID] == $past(POPF_DATA[`FLG_ID])
	) else $error("probe bit not writable");

	a_align_fault: assert property (
		(MEM_ACCESS && UNALIGNED && flags_r[`FLG_AC] && ALIGN_MASK_CTRL
			&& CUR_PRIV_LEVEL == `CPL_USER) |=> ALIGN_FAULT
	) else $error("alignment fault missing");

	a_vip_fault: assert property (
		vif_fault |=> VIF_GP && $stable(flags_r[`FLG_VIF])
	) else $error("pending virtual interrupt not faulted");

	a_vif_redirect: assert property (
		(IF_WRITE && ctx.vif_redirect && !vif_fault && !INTERRUPT_RETURN_DONE && !TASK_SWITCH && !POPF)
		|=> flags_r[`FLG_VIF] == $past(IF_VALUE) && $stable(flags_r[`FLG_IF])
	) else $error("redirected write missed virtual flag");

	a_lma_mismatch: assert property (
		(extended_feature_enables_hit && MSR_WR && priv_ok && !lma_match) |=> MSR_GP && MSR_ACK
	) else $error("mismatching long-mode write accepted");

	a_lme_alone: assert property (
		(PAGING_EN && paging_q_r && !extended_feature_enables_r[`EFR_LMA]) |=> !extended_feature_enables_r[`EFR_LMA]
	) else $error("long mode activated without paging enable");

	a_lma_on: assert property (
		(PAGING_EN && !paging_q_r && extended_feature_enables_r[`EFR_LME]) |=> extended_feature_enables_r[`EFR_LMA]
	) else $error("long mode not activated by paging enable");

	a_lma_off: assert property (
		!PAGING_EN |=> !extended_feature_enables_r[`EFR_LMA]
	) else $error("long mode active without paging");

	a_svm_undef: assert property (
		(SVM_INSN && !extended_feature_enables_r[`EFR_SECURE_VM_ENABLE]) |=> UD_FAULT
	) else $error("secure VM instruction not undefined");

	a_mode_follow: assert property (
		!extended_feature_enables_r[`EFR_LMA] |=> (OP_MODE == MODE_LEGACY)
	) else $error("legacy mode not reported");

	a_mode_long: assert property (
		(extended_feature_enables_r[`EFR_LMA] && CS_LONG) |=> (OP_MODE == MODE_64)
	) else $error("64-bit mode not reported");

	a_mode_compat: assert property (
		(extended_feature_enables_r[`EFR_LMA] && !CS_LONG) |=> (OP_MODE == MODE_COMPAT)
	) else $error("compatibility mode not reported");
endmodule
`default_nettype wire

// *** core/sysflags_defines.svh ***
`ifndef SYSFLAGS_DEFINES_SVH
`define SYSFLAGS_DEFINES_SVH

// Flags register bit positions
`define FLG_IF          9
`define FLG_IO_PRIVILEGE_LEVEL_LO     12
`define FLG_IO_PRIVILEGE_LEVEL_HI     13
`define FLG_RF          16
`define FLG_VM          17
`define FLG_AC          18
`define FLG_VIF         19
`define FLG_VIP         20
`define FLG_ID          21

// Bit 1 always reads as one
`define FLAGS_RESET     64'h0000_0000_0000_0002
// System bits kept by this block
`define FLAGS_KEEP_MASK 64'h0000_0000_003f_3202
// Bits a pop-flags may change; mode and resume bits excluded
`define FLAGS_POP_MASK  64'h0000_0000_003c_3200

// Extended feature register
`define EXTENDED_FEATURE_ENABLES_ADDR       32'hc000_0080
`define EXTENDED_FEATURE_ENABLES_RESET      64'h0000_0000_0000_0000
`define EXTENDED_FEATURE_ENABLES_WR_MASK    64'h0000_0000_0000_f901
`define EFR_SCE         0
`define EFR_LME         8
`define EFR_LMA         10
`define EFR_NXE         11
`define EFR_SECURE_VM_ENABLE        12
`define EFR_LONG_SEG_LIMIT_ENABLE       13
`define EFR_FAST_FP_SAVE_ENABLE       14
`define EFR_TCE         15

`define CPL_USER        2'h3
`define CPL_KERNEL      2'h0
`define IO_PRIVILEGE_LEVEL_TOP        2'h3

`endif

// *** core/sysflags_pkg.sv ***
`default_nettype none
package sysflags_pkg;
	typedef logic [63:0] reg64_t;
	typedef logic [1:0]  priv_t;
	typedef enum logic [1:0] {
		MODE_LEGACY = 2'b00,
		MODE_COMPAT = 2'b01,
		MODE_64     = 2'b10
	} op_mode_t;
endpackage
`default_nettype wire

// *** core/feature_ctx_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface feature_ctx_if;
	import sysflags_pkg::*;
	reg64_t   extended_feature_enables;
	priv_t    current_privilege_level;
	priv_t    io_privilege_level;
	logic     cs_long;
	logic     vme;
	logic     pvi;
	logic     syscall_ok;
	logic     nx_on;
	logic     limit_on;
	logic     fast_save;
	logic     tce_narrow;
	logic     vif_redirect;
	op_mode_t mode;
	modport decode (
		input  extended_feature_enables, current_privilege_level, io_privilege_level, cs_long, vme, pvi,
		output syscall_ok, nx_on, limit_on, fast_save, tce_narrow, vif_redirect, mode
	);
	modport bank (
		output extended_feature_enables, current_privilege_level, io_privilege_level, cs_long, vme, pvi,
		input  syscall_ok, nx_on, limit_on, fast_save, tce_narrow, vif_redirect, mode
	);
endinterface
`default_nettype wire

// *** core/feature_decode.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "sysflags_defines.svh"
module feature_decode (
	feature_ctx_if.decode ctx
);
	import sysflags_pkg::*;
	logic long_mode_active;
	logic in64;

	assign long_mode_active  = ctx.extended_feature_enables[`EFR_LMA];
	assign in64 = long_mode_active & ctx.cs_long;

	always_comb begin
		if (!long_mode_active) begin
			ctx.mode = MODE_LEGACY;
		end else if (ctx.cs_long) begin
			ctx.mode = MODE_64;
		end else begin
			ctx.mode = MODE_COMPAT;
		end
	end

	assign ctx.syscall_ok = ctx.extended_feature_enables[`EFR_SCE];
	assign ctx.nx_on      = ctx.extended_feature_enables[`EFR_NXE];
	assign ctx.limit_on   = ctx.extended_feature_enables[`EFR_LONG_SEG_LIMIT_ENABLE] & in64;
	// Only 64-bit code at kernel level skips the XMM image
	assign ctx.fast_save  = ctx.extended_feature_enables[`EFR_FAST_FP_SAVE_ENABLE] & in64 & (ctx.current_privilege_level == `CPL_KERNEL);
	assign ctx.tce_narrow = ctx.extended_feature_enables[`EFR_TCE];
	// Long mode honours only the protected-mode variant
	assign ctx.vif_redirect = (long_mode_active ? ctx.pvi : (ctx.vme | ctx.pvi)) & (ctx.io_privilege_level < `IO_PRIVILEGE_LEVEL_TOP);
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import sysflags_pkg::*;
	localparam logic [31:0] extended_feature_enables_a = 32'hc000_0080;
	localparam logic [9:0]  e_ret  = 10'h200;
	localparam logic [9:0]  e_interrupt_return = 10'h100;
	localparam logic [9:0]  e_tsw  = 10'h080;
	localparam logic [9:0]  e_tgx  = 10'h040;
	localparam logic [9:0]  e_pop  = 10'h020;
	localparam logic [9:0]  e_ifw  = 10'h010;
	localparam logic [9:0]  e_exc  = 10'h008;
	localparam logic [9:0]  e_str  = 10'h004;
	localparam logic [9:0]  e_mem  = 10'h002;
	localparam logic [9:0]  e_svm  = 10'h001;
	logic        core_clk, rst, if_value, db_ibp, unaligned, align_mask_ctrl, v86_mode_ext, prot_virt_ints;
	logic        paging_en, cs_long, msr_rd, msr_wr, msr_ack, msr_gp, stack_valid, lma_m;
	logic        align_fault, vif_gp, ud_fault, syscall_en, nx_en, limit_check_en, fast_fp_save;
	logic        tce_narrow, vif_redirect;
	logic [9:0]  evs;
	priv_t       cur_priv_level;
	op_mode_t    op_mode;
	logic [31:0] msr_addr;
	reg64_t      interrupt_return_flags, task_flags, popf_data, msr_wdata, msr_rdata, flags_q, extended_feature_enables_q, stack_flags, d, extended_feature_enables_m;
	logic [65:0] msr_e;
	logic [65:0] msr_q[$];
	logic        stack_q[$];
	logic [2:0]  fault_q[$];
	int          fail_count, checks_done, cycles;

	system_flags_bank i_system_flags_bank (
		.CORE_CLK(core_clk), .RST(rst), .RETIRE(evs[9]), .INTERRUPT_RETURN_DONE(evs[8]), .INTERRUPT_RETURN_FLAGS(interrupt_return_flags),
		.TASK_SWITCH(evs[7]), .TASK_GATE_XFER(evs[6]), .TASK_FLAGS(task_flags), .POPF(evs[5]),
		.POPF_DATA(popf_data), .IF_WRITE(evs[4]), .IF_VALUE(if_value), .EXC_TAKEN(evs[3]),
		.STR_INTERRUPTED(evs[2]), .DB_IBP(db_ibp), .MEM_ACCESS(evs[1]), .UNALIGNED(unaligned),
		.SVM_INSN(evs[0]), .ALIGN_MASK_CTRL(align_mask_ctrl), .V86_MODE_EXT(v86_mode_ext),
		.PROT_VIRT_INTS(prot_virt_ints), .CUR_PRIV_LEVEL(cur_priv_level), .PAGING_EN(paging_en),
		.CS_LONG(cs_long), .MSR_RD(msr_rd), .MSR_WR(msr_wr), .MSR_ADDR(msr_addr), .MSR_WDATA(msr_wdata),
		.MSR_RDATA(msr_rdata), .MSR_ACK(msr_ack), .MSR_GP(msr_gp), .FLAGS_Q(flags_q), .EXTENDED_FEATURE_ENABLES_Q(extended_feature_enables_q),
		.STACK_FLAGS(stack_flags), .STACK_VALID(stack_valid), .ALIGN_FAULT(align_fault), .VIF_GP(vif_gp),
		.UD_FAULT(ud_fault), .SYSCALL_EN(syscall_en), .NX_EN(nx_en), .LIMIT_CHECK_EN(limit_check_en),
		.FAST_FP_SAVE(fast_fp_save), .TCE_NARROW(tce_narrow), .VIF_REDIRECT(vif_redirect), .OP_MODE(op_mode)
	);

	function automatic void tally(input string what, input reg64_t got, input reg64_t exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endfunction

	task automatic cmp_ans(input string what, input reg64_t got, input reg64_t exp);
		tally({"answer ", what}, got, exp);
	endtask

	task automatic cmp_bit(input string what, input logic got, input logic exp);
		tally({"level ", what}, 64'(got), 64'(exp));
	endtask

	// Ends just after a falling edge so registered outputs have settled
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask

	task automatic ev(input logic [9:0] m);
		@(posedge core_clk);
		evs <= m;
		@(posedge core_clk);
		evs <= 10'h000;
		tick(3);
	endtask

	// Expected answer is noted before the request; only the answer edge pops it
	task automatic msr(input logic wr, input logic [31:0] a, input reg64_t v, input priv_t p);
		logic ok;
		ok = p == 2'h0 && (!wr || v[10] == lma_m);
		if (a == extended_feature_enables_a) msr_q.push_back({wr, !ok, ok && !wr ? extended_feature_enables_m | {53'h0, lma_m, 10'h0} : 64'h0});
		if (a == extended_feature_enables_a && wr && ok) extended_feature_enables_m = v & 64'h0000_0000_0000_f901;
		@(posedge core_clk);
		{msr_wr, msr_rd, msr_addr, msr_wdata, cur_priv_level} <= {wr, !wr, a, v, p};
		@(posedge core_clk);
		{msr_wr, msr_rd} <= 2'b00;
		tick(1);
	endtask

	task automatic give_verdict();
		fail_count += msr_q.size() + stack_q.size() + fault_q.size();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	always @(negedge core_clk) begin
		if (!rst && msr_ack === 1'b1) begin
			if (msr_q.size() == 0) begin
				tally("stray ack", 64'h1, 64'h0);
			end else begin
				msr_e = msr_q.pop_front();
				cmp_ans("gp", 64'(msr_gp), 64'(msr_e[64]));
				if (!msr_e[65]) cmp_ans("rdata", msr_rdata, msr_e[63:0]);
			end
		end
		if (!rst && stack_valid === 1'b1) cmp_ans("stack", 64'(stack_flags[16]), stack_q.size() ? 64'(stack_q.pop_front()) : 64'h2);
		if (!rst && {align_fault, vif_gp, ud_fault} !== 3'b000) cmp_ans("fault", 64'({align_fault, vif_gp, ud_fault}), fault_q.size() ? 64'(fault_q.pop_front()) : 64'hf);
	end

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			give_verdict();
		end
	end

	initial begin
		{rst, if_value, db_ibp, unaligned, align_mask_ctrl, v86_mode_ext, prot_virt_ints} = 7'h40;
		{paging_en, cs_long, msr_rd, msr_wr, evs, cur_priv_level, msr_addr} = '0;
		{interrupt_return_flags, task_flags, popf_data, msr_wdata, extended_feature_enables_m} = '0;
		{fail_count, checks_done, cycles, lma_m} = '0;
		void'($urandom(32'hed91628c));
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		msr(1'b0, extended_feature_enables_a, '0, 2'h0);
		cmp_bit("legacy", op_mode == MODE_LEGACY, 1'b1);
		repeat (4) begin
			d = {$urandom, $urandom} & ~64'h400;
			msr(1'b1, extended_feature_enables_a, d, 2'h0);
			msr(1'b0, extended_feature_enables_a, '0, 2'h0);
			if (!d[12]) fault_q.push_back(3'b001);
			ev(e_svm);
			cmp_bit("sce", syscall_en, d[0]);
			cmp_bit("nx", nx_en, d[11]);
			cmp_bit("tce", tce_narrow, d[15]);
		end
		msr(1'b1, extended_feature_enables_a, 64'h401, 2'h0);
		msr(1'b0, extended_feature_enables_a, '0, 2'h3);
		msr(1'b1, extended_feature_enables_a, 64'h1, 2'h3);
		msr(1'b0, extended_feature_enables_a + 32'h1, '0, 2'h0);
		msr(1'b0, extended_feature_enables_a, '0, 2'h0);
		// Enable first, paging later: activation must wait for paging
		msr(1'b1, extended_feature_enables_a, 64'h6101, 2'h0);
		cmp_bit("act", extended_feature_enables_q[10], 1'b0);
		@(posedge core_clk) {paging_en, cs_long, lma_m} <= 3'b111;
		tick(4);
		msr(1'b0, extended_feature_enables_a, '0, 2'h0);
		cmp_bit("m64", op_mode == MODE_64, 1'b1);
		cmp_bit("ffx", fast_fp_save, 1'b1);
		cmp_bit("lim", limit_check_en, 1'b1);
		msr(1'b1, extended_feature_enables_a, 64'h6101, 2'h0);
		@(posedge core_clk) {cs_long, v86_mode_ext} <= 2'b01;
		tick(4);
		cmp_bit("cmp", op_mode == MODE_COMPAT, 1'b1);
		cmp_bit("ffx", fast_fp_save, 1'b0);
		cmp_bit("vr", vif_redirect, 1'b0);
		@(posedge core_clk) prot_virt_ints <= 1'b1;
		tick(3);
		cmp_bit("vr", vif_redirect, 1'b1);
		@(posedge core_clk) {paging_en, prot_virt_ints, v86_mode_ext, lma_m} <= 4'h0;
		tick(4);
		cmp_bit("legacy", op_mode == MODE_LEGACY, 1'b1);
		// Enable while paging is already on must not activate
		msr(1'b1, extended_feature_enables_a, 64'h1, 2'h0);
		@(posedge core_clk) paging_en <= 1'b1;
		tick(2);
		msr(1'b1, extended_feature_enables_a, 64'h101, 2'h0);
		tick(2);
		cmp_bit("act", extended_feature_enables_q[10], 1'b0);
		@(posedge core_clk) paging_en <= 1'b0;
		@(posedge core_clk) interrupt_return_flags <= 64'h0025_0002;
		ev(e_interrupt_return);
		ev(e_ret);
		cmp_bit("rf", flags_q[16], 1'b1);
		ev(e_ret);
		cmp_bit("rf", flags_q[16], 1'b0);
		@(posedge core_clk) align_mask_ctrl <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk) {cur_priv_level, unaligned} <= {i[1] ? 2'h3 : 2'h0, i[0]};
			if (i == 3) fault_q.push_back(3'b100);
			ev(e_mem);
		end
		@(posedge core_clk) cur_priv_level <= 2'h0;
		for (int i = 0; i < 3; i++) begin
			@(posedge core_clk) db_ibp <= i == 1;
			stack_q.push_back(i != 1);
			ev(i == 2 ? e_str : e_exc);
		end
		@(posedge core_clk) task_flags <= 64'h0003_0002;
		ev(e_tsw | e_tgx);
		ev(e_ret);
		cmp_bit("rf", flags_q[16], 1'b1);
		cmp_bit("vm", flags_q[17], 1'b1);
		@(posedge core_clk) popf_data <= '1;
		ev(e_pop);
		cmp_bit("id", flags_q[21], 1'b1);
		@(posedge core_clk) popf_data <= '0;
		ev(e_pop);
		cmp_bit("id", flags_q[21], 1'b0);
		cmp_bit("vm", flags_q[17], 1'b1);
		cmp_bit("rf", flags_q[16], 1'b1);
		@(posedge core_clk) {v86_mode_ext, if_value} <= 2'b11;
		ev(e_ifw);
		cmp_bit("vif", flags_q[19], 1'b1);
		cmp_bit("if", flags_q[9], 1'b0);
		cmp_bit("vr", vif_redirect, 1'b1);
		@(posedge core_clk) popf_data <= 64'h0010_0000;
		ev(e_pop);
		fault_q.push_back(3'b010);
		ev(e_ifw);
		cmp_bit("vif", flags_q[19], 1'b0);
		// Without extensions the write lands on the real flag
		@(posedge core_clk) v86_mode_ext <= 1'b0;
		ev(e_ifw);
		cmp_bit("if", flags_q[9], 1'b1);
		cmp_bit("vr", vif_redirect, 1'b0);
		give_verdict();
	end
endmodule
`default_nettype wire
